// ### common/txdc_defines.vh
// constants of the transmit descriptor control decoder
`ifndef TXDC_DEFINES_VH
`define TXDC_DEFINES_VH

// register byte offsets
`define TXDC_OFS_CTRL        12'h000
`define TXDC_OFS_RING_BASE   12'h004
`define TXDC_OFS_IRQ_STATUS  12'h008
`define TXDC_OFS_IRQ_MASK    12'h00C
`define TXDC_OFS_CUR_DESC    12'h010
`define TXDC_OFS_ENG_STATE   12'h014

// control register fields
`define TXDC_CTRL_RUN        0

// interrupt status fields
`define TXDC_IRQ_TX_DONE     0
`define TXDC_IRQ_RING_WRAP   1
`define TXDC_IRQ_W           2

// descriptor control word fields
`define TXDC_FRAME_IRQ_BIT   31
`define TXDC_LAST_SEG_BIT    30
`define TXDC_FIRST_SEG_BIT   29
`define TXDC_CRC_INH_BIT     26
`define TXDC_RING_END_BIT    25
`define TXDC_CHAIN_BIT       24
`define TXDC_CNT2_HI         21
`define TXDC_CNT2_LO         11
`define TXDC_CNT1_HI         10
`define TXDC_CNT1_LO         0
`define TXDC_CNT_W           11

// descriptor layout in host memory
`define TXDC_WORD_STEP       32'h0000_0004
`define TXDC_DESC_STEP       32'h0000_0010
`define TXDC_IDX_CTRL        2'h1
`define TXDC_IDX_BUF1        2'h2
`define TXDC_IDX_WORD3       2'h3

// reset values
`define TXDC_RST_WORD        32'h0000_0000
`define TXDC_RST_IRQ         2'h0

`endif

// ### rtl/txdc_engine.v
// transmit descriptor fetch and control word decode engine with apb registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - each new frame starts by fetching its first descriptor and taking the frame controls from it.
// - words 1 to 3 of every descriptor are fetched before any of its buffer data is read.
// - a frame whose first descriptor requests it sets interrupt status bit 0 once transmitted.
// - the frame interrupt request is taken only from a first-segment descriptor.
// - control bit 30 marks the last descriptor of a frame and is evaluated in every descriptor.
// - control bit 29 marks the first descriptor of a frame and is evaluated in every descriptor.
// - with both segment flags set the single descriptor carries the whole frame.
// - with both segment flags clear the descriptor is a middle segment.
// - a set crc inhibit bit 26 sends the frame without crc, otherwise crc is appended.
// - the crc inhibit setting is taken only from a first-segment descriptor.
// - a set ring-end bit 25 loads the next descriptor pointer from the ring base register.
// - ring-end wins over the chained-pointer bit 24.
// - bit 24 set makes word 3 the next descriptor address, clear without ring-end makes it the second buffer address.
// - ring-end and chained-pointer flags are evaluated in every descriptor.
// - buffer byte counts come from bits 10:0 and 21:11 and a zero count skips that buffer.
`include "txdc_defines.vh"

module txdc_engine (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  output reg         tx_valid,
  output reg  [31:0] tx_data,
  output reg         tx_last,
  output reg         tx_crc_inhibit,
  input  wire        tx_ready,
  input  wire        tx_done,
  output reg         irq
);

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_FETCH  = 3'h1;
  localparam [2:0] S_DECODE = 3'h2;
  localparam [2:0] S_BUF    = 3'h3;
  localparam [2:0] S_READ   = 3'h4;
  localparam [2:0] S_PUSH   = 3'h5;
  localparam [2:0] S_WAIT   = 3'h6;
  localparam [2:0] S_NEXT   = 3'h7;

  // number of 32-bit words that hold a buffer of the given byte count
  function [9:0] word_count;
    input [`TXDC_CNT_W-1:0] cnt;
    reg   [`TXDC_CNT_W:0]   sum;
    begin
      sum        = {1'b0, cnt} + 12'h003;
      word_count = sum[`TXDC_CNT_W:2];
    end
  endfunction

  // reads are whole words, taken from the word boundary at or below the start
  function [31:0] word_addr;
    input [31:0] byte_addr;
    begin
      word_addr = {byte_addr[31:2], 2'h0};
    end
  endfunction

  // next descriptor pointer: ring end first, then chaining, else the following descriptor
  function [31:0] next_desc;
    input        wrap;
    input        link;
    input [31:0] base;
    input [31:0] link_addr;
    input [31:0] cur;
    begin
      if (wrap) begin
        next_desc = base;
      end else if (link) begin
        next_desc = link_addr;
      end else begin
        next_desc = cur + `TXDC_DESC_STEP;
      end
    end
  endfunction

  reg [2:0]               state_reg;
  reg                     run_reg;
  reg [31:0]              ring_base_reg;
  reg [31:0]              cur_desc_reg;
  reg [`TXDC_IRQ_W-1:0]   irq_status_reg;
  reg [`TXDC_IRQ_W-1:0]   irq_status_next;
  reg [`TXDC_IRQ_W-1:0]   irq_mask_reg;
  reg [31:0]              ctrl_word_reg;
  reg [31:0]              buf1_addr_reg;
  reg [31:0]              word3_reg;
  reg [1:0]               widx_reg;
  reg [1:0]               buf_sel_reg;
  reg [9:0]               words_reg;
  reg                     buf_final_reg;
  reg                     frame_irq_reg;
  reg                     in_frame_reg;

  wire                    apb_setup;
  wire                    apb_access;
  wire                    apb_write;
  wire                    apb_read;
  wire                    addr_ok;
  wire                    frame_irq_req;
  wire                    last_seg;
  wire                    first_seg;
  wire                    crc_inh;
  wire                    ring_end;
  wire                    chained;
  wire [`TXDC_CNT_W-1:0]  cnt1;
  wire [`TXDC_CNT_W-1:0]  cnt2;
  wire                    ev_done;
  wire                    ev_wrap;
  reg  [31:0]             rd_mux;

  // control word decode, applied to every descriptor
  assign frame_irq_req = ctrl_word_reg[`TXDC_FRAME_IRQ_BIT];
  assign last_seg      = ctrl_word_reg[`TXDC_LAST_SEG_BIT];
  assign first_seg     = ctrl_word_reg[`TXDC_FIRST_SEG_BIT];
  assign crc_inh       = ctrl_word_reg[`TXDC_CRC_INH_BIT];
  assign ring_end      = ctrl_word_reg[`TXDC_RING_END_BIT];
  assign chained       = ctrl_word_reg[`TXDC_CHAIN_BIT];
  assign cnt1          = ctrl_word_reg[`TXDC_CNT1_HI:`TXDC_CNT1_LO];
  assign cnt2          = ctrl_word_reg[`TXDC_CNT2_HI:`TXDC_CNT2_LO];

  // apb decode
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable & pready;
  assign apb_write  = apb_access & pwrite;
  assign apb_read   = apb_access & ~pwrite;
  assign addr_ok    = (paddr == `TXDC_OFS_CTRL) | (paddr == `TXDC_OFS_RING_BASE) |
                      (paddr == `TXDC_OFS_IRQ_STATUS) | (paddr == `TXDC_OFS_IRQ_MASK) |
                      (paddr == `TXDC_OFS_CUR_DESC) | (paddr == `TXDC_OFS_ENG_STATE);

  // events
  assign ev_done = (state_reg == S_WAIT) & tx_done & frame_irq_reg;
  // wrap event as the pointer returns to the ring base
  assign ev_wrap = (state_reg == S_NEXT) & ring_end;

  always @* begin
    rd_mux = `TXDC_RST_WORD;
    case (paddr)
      `TXDC_OFS_CTRL:       rd_mux[`TXDC_CTRL_RUN] = run_reg;
      `TXDC_OFS_RING_BASE:  rd_mux = ring_base_reg;
      `TXDC_OFS_IRQ_STATUS: rd_mux[`TXDC_IRQ_W-1:0] = irq_status_reg;
      `TXDC_OFS_IRQ_MASK:   rd_mux[`TXDC_IRQ_W-1:0] = irq_mask_reg;
      `TXDC_OFS_CUR_DESC:   rd_mux = cur_desc_reg;
      `TXDC_OFS_ENG_STATE:  rd_mux = {26'h0, crc_inh & in_frame_reg, frame_irq_reg, in_frame_reg, state_reg};
      default:              rd_mux = `TXDC_RST_WORD;
    endcase
  end

  // sticky status: read clears, a new event in the same cycle wins
  always @* begin
    irq_status_next = irq_status_reg;
    if (apb_read && (paddr == `TXDC_OFS_IRQ_STATUS)) begin
      irq_status_next = `TXDC_RST_IRQ;
    end
    if (ev_done) begin
      irq_status_next[`TXDC_IRQ_TX_DONE] = 1'b1;
    end
    if (ev_wrap) begin
      irq_status_next[`TXDC_IRQ_RING_WRAP] = 1'b1;
    end
  end

  // apb slave and registers
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata         <= `TXDC_RST_WORD;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      run_reg        <= 1'b0;
      ring_base_reg  <= `TXDC_RST_WORD;
      irq_status_reg <= `TXDC_RST_IRQ;
      irq_mask_reg   <= `TXDC_RST_IRQ;
      irq            <= 1'b0;
    end else begin
      // every setup is answered in the next cycle, no wait states
      pready         <= apb_setup;
      irq_status_reg <= irq_status_next;
      irq            <= |(irq_status_next & irq_mask_reg);
      if (apb_setup) begin
        prdata  <= pwrite ? `TXDC_RST_WORD : rd_mux;
        pslverr <= ~addr_ok;
      end else if (apb_access) begin
        prdata  <= `TXDC_RST_WORD;
        pslverr <= 1'b0;
      end
      if (apb_write) begin
        case (paddr)
          `TXDC_OFS_CTRL:      run_reg       <= pwdata[`TXDC_CTRL_RUN];
          `TXDC_OFS_RING_BASE: ring_base_reg <= pwdata;
          `TXDC_OFS_IRQ_MASK:  irq_mask_reg  <= pwdata[`TXDC_IRQ_W-1:0];
          default:             run_reg       <= run_reg;
        endcase
      end
    end
  end

  // descriptor engine
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= S_IDLE;
      cur_desc_reg   <= `TXDC_RST_WORD;
      ctrl_word_reg  <= `TXDC_RST_WORD;
      buf1_addr_reg  <= `TXDC_RST_WORD;
      word3_reg      <= `TXDC_RST_WORD;
      widx_reg       <= 2'h0;
      buf_sel_reg    <= 2'h0;
      words_reg      <= 10'h000;
      buf_final_reg  <= 1'b0;
      frame_irq_reg  <= 1'b0;
      in_frame_reg   <= 1'b0;
      mem_req        <= 1'b0;
      mem_addr       <= `TXDC_RST_WORD;
      tx_valid       <= 1'b0;
      tx_data        <= `TXDC_RST_WORD;
      tx_last        <= 1'b0;
      tx_crc_inhibit <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          // a ring base write while idle restarts the ring from its base
          if (apb_write && (paddr == `TXDC_OFS_RING_BASE)) begin
            cur_desc_reg <= pwdata;
          end else if (run_reg) begin
            // word 0 holds ownership status, which this block leaves out
            mem_req   <= 1'b1;
            mem_addr  <= word_addr(cur_desc_reg) + `TXDC_WORD_STEP;
            widx_reg  <= `TXDC_IDX_CTRL;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            case (widx_reg)
              `TXDC_IDX_CTRL: ctrl_word_reg <= mem_rdata;
              `TXDC_IDX_BUF1: buf1_addr_reg <= mem_rdata;
              default:        word3_reg     <= mem_rdata;
            endcase
            if (widx_reg == `TXDC_IDX_WORD3) begin
              mem_req   <= 1'b0;
              state_reg <= S_DECODE;
            end else begin
              mem_addr <= mem_addr + `TXDC_WORD_STEP;
              widx_reg <= widx_reg + 2'h1;
            end
          end
        end
        S_DECODE: begin
          // frame controls stay with the first descriptor until the frame ends
          buf_sel_reg <= 2'h0;
          state_reg   <= S_BUF;
          if (first_seg) begin
            frame_irq_reg  <= frame_irq_req;
            tx_crc_inhibit <= crc_inh;
            in_frame_reg   <= 1'b1;
          end else if (!in_frame_reg) begin
            frame_irq_reg  <= 1'b0;
            tx_crc_inhibit <= 1'b0;
          end
        end
        S_BUF: begin
          // buffer 1, then buffer 2 unless word 3 is a pointer or ring end is set, then frame end or next descriptor
          case (buf_sel_reg)
            2'h0: begin
              buf_sel_reg <= 2'h1;
              if (cnt1 != 11'h000) begin
                mem_req       <= 1'b1;
                mem_addr      <= word_addr(buf1_addr_reg);
                words_reg     <= word_count(cnt1);
                // buffer 1 ends the frame when no second buffer follows it
                buf_final_reg <= last_seg & (chained | ring_end | (cnt2 == 11'h000));
                state_reg     <= S_READ;
              end
            end
            2'h1: begin
              buf_sel_reg <= 2'h2;
              if (!chained && !ring_end && (cnt2 != 11'h000)) begin
                mem_req       <= 1'b1;
                mem_addr      <= word_addr(word3_reg);
                words_reg     <= word_count(cnt2);
                buf_final_reg <= last_seg;
                state_reg     <= S_READ;
              end
            end
            default: begin
              state_reg <= last_seg ? S_WAIT : S_NEXT;
            end
          endcase
        end
        S_READ: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            tx_valid  <= 1'b1;
            tx_data   <= mem_rdata;
            tx_last   <= buf_final_reg & (words_reg == 10'h001);
            state_reg <= S_PUSH;
          end
        end
        S_PUSH: begin
          // one word in flight: the next read starts once this one is taken
          if (tx_ready) begin
            tx_valid  <= 1'b0;
            tx_last   <= 1'b0;
            words_reg <= words_reg - 10'h001;
            if (words_reg == 10'h001) begin
              state_reg <= S_BUF;
            end else begin
              mem_req   <= 1'b1;
              mem_addr  <= mem_addr + `TXDC_WORD_STEP;
              state_reg <= S_READ;
            end
          end
        end
        S_WAIT: begin
          // the frame stays open until the transmit path reports it sent
          if (tx_done) begin
            in_frame_reg <= 1'b0;
            state_reg    <= S_NEXT;
          end
        end
        S_NEXT: begin
          cur_desc_reg <= next_desc(ring_end, chained, ring_base_reg, word3_reg, cur_desc_reg);
          state_reg    <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // txdc_engine
`default_nettype wire

// ### testbench/txdc_mem_model.sv
// host memory model answering descriptor and buffer reads
`timescale 1ns/1ps
`default_nettype none
module txdc_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [1:0]  slow,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0]  wait_cnt;
  // data bus flips when not answering so stale data never looks valid
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_cnt == slow) begin
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:2]];
          wait_cnt  <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // txdc_mem_model
`default_nettype wire

// ### testbench/txdc_engine_monitor.sv
// port assertions of the descriptor engine
`timescale 1ns/1ps
`default_nettype none
module txdc_engine_monitor (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_last,
  input wire logic        tx_crc_inhibit,
  input wire logic        tx_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_data_after_ack: assert property ($rose(tx_valid) |-> $past(mem_ack)) else $error("push without fetch");
  a_fetch_or_push: assert property (!(mem_req && tx_valid)) else $error("fetch and push overlap");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request moved");
  a_word_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("word changed");
  a_one_in_flight: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("words back to back");
  a_crc_in_frame: assert property ($changed(tx_crc_inhibit) |-> !tx_valid) else $error("crc moved mid word");
  a_wait_frame_end: assert property (tx_valid && tx_ready && tx_last |=> !mem_req [*2]) else $error("fetch early");
  a_word_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'h0) else $error("unaligned read");
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no apb answer");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("err data");
endmodule // txdc_engine_monitor
bind txdc_engine txdc_engine_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_crc_inhibit(tx_crc_inhibit),
  .tx_ready(tx_ready));
`default_nettype wire

// ### testbench/test_tx_descriptor_control_decode.sv
// testbench of the descriptor engine
`timescale 1ns/1ps
`default_nettype none
`include "txdc_defines.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_tx_descriptor_control_decode;
  logic        clk_sys, nrst, psel, penable, pwrite, tx_ready, tx_done, mem_req, mem_ack;
  logic        tx_valid, tx_last, tx_crc_inhibit, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_rdata, tx_data;
  logic [1:0]  slow;
  int          n_errors, checks_done;
  int          cycles = 0;
  txdc_engine dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_crc_inhibit(tx_crc_inhibit), .tx_ready(tx_ready), .tx_done(tx_done), .irq(irq));
  txdc_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    @(posedge clk_sys) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
    if (!w) `CHK(prdata, exp)
    `CHK(pslverr, err)
    {psel, penable} <= 2'h0;
  endtask
  task take(input logic [31:0] a, input logic l, input logic c);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (tx_valid !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk_sys);
    end
    `CHK(tx_data, 32'hD000_0000 | a)
    `CHK({tx_last, tx_crc_inhibit}, {l, c})
    @(posedge clk_sys) tx_ready <= 1'b1;
    @(posedge clk_sys) tx_ready <= 1'b0;
  endtask
  task done;
    repeat (3) @(posedge clk_sys);
    tx_done <= 1'b1;
    @(posedge clk_sys) tx_done <= 1'b0;
  endtask
  task desc(input logic [7:0] a, input logic [31:0] c, input logic [31:0] b, input logic [31:0] w);
    u_mem.mem[a[7:2] + 6'h1] = c;
    u_mem.mem[a[7:2] + 6'h2] = b;
    u_mem.mem[a[7:2] + 6'h3] = w;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {nrst, psel, penable, pwrite, tx_ready, tx_done} = 6'h00;
    {paddr, pwdata, slow, n_errors, checks_done} = '0;
    for (int i = 0; i < 64; i++) u_mem.mem[i] = 32'hD000_0000 | (i << 2);
    desc(8'h10, 32'hE000_0008, 32'h0000_0080, 32'h0000_0000);
    desc(8'h20, 32'h2400_2004, 32'h0000_0090, 32'h0000_0098);
    desc(8'h30, 32'h8100_0004, 32'h0000_00A0, 32'h0000_0050);
    desc(8'h50, 32'h4300_0004, 32'h0000_00A4, 32'h0000_0040);
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, `TXDC_OFS_RING_BASE, 32'h0, `TXDC_RST_WORD, 1'b0);
    apb(1'b0, `TXDC_OFS_IRQ_MASK, 32'h0, `TXDC_RST_WORD, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, `TXDC_OFS_RING_BASE, 32'h0000_0010, 32'h0, 1'b0);
    apb(1'b1, `TXDC_OFS_IRQ_MASK, 32'h0000_0003, 32'h0, 1'b0);
    apb(1'b1, `TXDC_OFS_CTRL, 32'h0000_0001, 32'h0, 1'b0);
    $display("test registers done");
    take(32'h80, 1'b0, 1'b0);
    take(32'h84, 1'b1, 1'b0);
    done();
    repeat (4) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    apb(1'b0, `TXDC_OFS_IRQ_STATUS, 32'h0, 32'h0000_0001, 1'b0);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    $display("test single frame done");
    slow <= 2'h2;
    apb(1'b1, `TXDC_OFS_IRQ_MASK, 32'h0000_0001, 32'h0, 1'b0);
    take(32'h90, 1'b0, 1'b1);
    take(32'h98, 1'b0, 1'b1);
    take(32'hA0, 1'b0, 1'b1);
    take(32'hA4, 1'b1, 1'b1);
    apb(1'b1, `TXDC_OFS_CTRL, 32'h0000_0000, 32'h0, 1'b0);
    done();
    repeat (4) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    apb(1'b0, `TXDC_OFS_IRQ_STATUS, 32'h0, 32'h0000_0002, 1'b0);
    apb(1'b0, `TXDC_OFS_CUR_DESC, 32'h0, 32'h0000_0010, 1'b0);
    $display("test chained frame done");
    summarize();
  end
endmodule // test_tx_descriptor_control_decode
`default_nettype wire
